/* include/i2cw_defs.svh */
`ifndef I2CW_DEFS_SVH
`define I2CW_DEFS_SVH
// ----------------------------------------
// Address matcher constants
// ----------------------------------------
`define I2CW_ADDR7_W     7
`define I2CW_ADDR10_W    10
`define I2CW_HDR10       5'h1e
`define I2CW_BYTE_W      8
`endif

/* include/i2cw_pkg.sv */
package i2cw_pkg;
  typedef enum logic [2:0] {
    I2CW_IDLE,
    I2CW_WAIT_OSC,
    I2CW_RX_ADDR,
    I2CW_RX_ADDR2,
    I2CW_ACK,
    I2CW_HOLD,
    I2CW_RUN
  } i2cw_state_t;
endpackage

/* design/i2cw_stop_wake.sv */
// Functional notes
// (RQ1) Wake processor from Stop on own address
// (RQ2) Wake only when fast oscillator is kernel clock
// (RQ3) On START request oscillator, stretch SCL
// (RQ4) Receive address using fast oscillator kernel clock
// (RQ5) On match, hold SCL through wakeup
// (RQ6) Release stretch when software clears match flag
// (RQ7) On mismatch drop request, no wakeup
// (RQ8) Address match in Stop raises wakeup interrupt
// (RQ9) Oscillator request dropped when no longer needed
// (RQ10) Release SCL once oscillator reports stable
`timescale 1ns/1ps
`default_nettype none
`include "i2cw_defs.svh"

module i2cw_stop_wake
  import i2cw_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     scl_in,
  output logic                          scl_out,
  output logic                          scl_oe,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     stop_mode,
  input  wire logic                     kernel_is_fast_osc,
  input  wire logic                     addr_10bit,
  input  wire logic [`I2CW_ADDR10_W-1:0] own_addr,
  input  wire logic                     osc_ready,
  input  wire logic                     addr_flag_clear,
  output logic                          osc_request,
  output logic                          addr_match_flag,
  output logic                          wakeup_irq
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] rdy_sync;
  logic       scl_d;
  logic       sda_d;

  // Two stages before any logic looks at the pins
  // Bus lines reset high to match the idle bus, so no false START
  // is seen straight after reset; ready resets low for the same reason
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      rdy_sync <= 2'h0;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      rdy_sync <= {rdy_sync[0], osc_ready};
    end
  end

  // Previous synchronised levels for edge detection
  // The third stage adds no latency: edges are flagged as soon as
  // the synchroniser output changes, and that output also feeds the logic
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------
  // Wakeup sequencer
  // ----------------------------------------
  i2cw_state_t state;
  logic [`I2CW_BYTE_W-1:0] shreg;
  logic [3:0]              bitcnt;
  logic                    hit;
  logic                    second;
  logic                    ack_hi;

  // Bit counter is four bits wide so it reaches eight without wrapping
  // Match against the received byte; 10-bit mode needs header then low byte
  // Read direction is never matched here: a read cannot wake the core
  always_comb begin
    hit = 1'b0;
    if (!addr_10bit)
      hit = (shreg[7:1] == own_addr[6:0]) & ~shreg[0];
    else if (!second)
      hit = (shreg[7:3] == `I2CW_HDR10) & (shreg[2:1] == own_addr[9:8]) & ~shreg[0];
    else
      hit = (shreg == own_addr[7:0]);
  end

  // Sequencing; a START while receiving restarts the bit count (second byte flag kept), a STOP drops back to idle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state  <= I2CW_IDLE;
      shreg  <= '0;
      bitcnt <= '0;
      second <= 1'b0;
      ack_hi <= 1'b0;
    end else begin
      case (state)
        I2CW_IDLE: begin
          // Only armed in Stop with the fast oscillator as kernel clock
          if (start_det && stop_mode && kernel_is_fast_osc) begin // [RQ2] [RQ3]
            state  <= I2CW_WAIT_OSC;
            second <= 1'b0;
          end
        end
        I2CW_WAIT_OSC: begin
          bitcnt <= '0;
          if (rdy_sync[1])
            state <= I2CW_RX_ADDR;                  // [RQ10]
        end
        I2CW_RX_ADDR: begin
          if (stop_det)
            state <= I2CW_IDLE;
          else if (start_det)
            bitcnt <= '0;
          else if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};          // [RQ4]
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            if (hit) begin
              state  <= I2CW_ACK;
              ack_hi <= 1'b0;
            end else
              state <= I2CW_IDLE;                   // [RQ7]
          end
        end
        I2CW_ACK: begin
          // Drive ACK low for one SCL pulse
          if (scl_rise)
            ack_hi <= 1'b1;
          else if (scl_fall && ack_hi) begin
            if (addr_10bit && !second) begin
              second <= 1'b1;
              bitcnt <= '0;
              state  <= I2CW_RX_ADDR;
            end else
              state <= I2CW_HOLD;                   // [RQ1] [RQ5]
          end
        end
        I2CW_HOLD: begin
          if (addr_flag_clear && addr_match_flag)
            state <= I2CW_RUN;                      // [RQ6]
        end
        I2CW_RUN: begin
          // Normal transfer belongs to the running core; wait for bus end
          if (stop_det)
            state <= I2CW_IDLE;
        end
        default: state <= I2CW_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs, all registered
  // ----------------------------------------
  // SCL low while waiting for oscillator or processor wakeup
  // Pads are open drain: the block only ever pulls low, and the
  // enables lag the state by one cycle, well inside the SCL low phase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_oe  <= 1'b0;
      scl_out <= 1'b1;
      sda_oe  <= 1'b0;
      sda_out <= 1'b1;
    end else begin
      scl_oe  <= (state == I2CW_WAIT_OSC) | (state == I2CW_HOLD); // [RQ3] [RQ5]
      scl_out <= 1'b0;
      sda_oe  <= (state == I2CW_ACK);
      sda_out <= 1'b0;
    end
  end

  // Request held only from START until mismatch or bus end
  // Kept through the running transfer so the kernel clock stays alive
  // until the bus is free; dropping it earlier would starve the core
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      osc_request <= 1'b0;
    else
      osc_request <= (state != I2CW_IDLE);          // [RQ3] [RQ9]
  end

  // Match flag: a fresh match wins over a clear in the same cycle
  // Wakeup follows the hold state, so it rises one cycle after the
  // flag and falls as soon as software lets the bus go
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addr_match_flag <= 1'b0;
      wakeup_irq      <= 1'b0;
    end else begin
      if (state == I2CW_ACK && scl_fall && ack_hi && !(addr_10bit && !second))
        addr_match_flag <= 1'b1;
      else if (addr_flag_clear)
        addr_match_flag <= 1'b0;
      wakeup_irq <= (state == I2CW_HOLD) & stop_mode; // [RQ8]
    end
  end

endmodule // i2cw_stop_wake
`default_nettype wire

/* sim/i2cw_master.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cw_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_m,
  output logic      sda_m
);
  int tmo = 0;
  // ACK slots seen pulled low by the block
  int acks = 0;
  initial scl_m = 1'b1;
  initial sda_m = 1'b1;
  // One clock; a stretched SCL is waited out, bounded
  task automatic clk_bit(input logic b, input logic last, output logic s);
    int n;
    sda_m = b;
    #24 scl_m = 1'b1;
    for (n = 0; n < 3000 && !scl; n++) #1;
    tmo += (n == 3000);
    s = sda;
    #24 if (last) sda_m = 1'b1;
    else scl_m = 1'b0;
  endtask
  // START, bytes MSB first with ACK slots, STOP
  task automatic xfer(input logic [15:0] d, input logic two);
    logic s;
    sda_m = 1'b0;
    #48 scl_m = 1'b0;
    for (int i = 15; i >= (two ? 0 : 8); i--) begin
      clk_bit(d[i], 1'b0, s);
      if (i % 8 == 0) begin
        clk_bit(1'b1, 1'b0, s);
        acks += (s === 1'b0);
      end
    end
    clk_bit(1'b0, 1'b1, s);
  endtask
endmodule // i2cw_master
`default_nettype wire

/* sim/i2cw_stop_wake_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cw_stop_wake_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic stop_mode,
  input wire logic kernel_is_fast_osc,
  input wire logic osc_ready,
  input wire logic addr_flag_clear,
  input wire logic osc_request,
  input wire logic addr_match_flag,
  input wire logic wakeup_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  req_gate_a: assert property ($rose(osc_request) |-> stop_mode && kernel_is_fast_osc)
    else $error("bad request");
  req_hold_a: assert property ($rose(osc_request) |-> scl_oe && !scl_out)
    else $error("no stretch");
  osc_rel_a: assert property ($rose(osc_ready) && osc_request |-> ##[1:8] !scl_oe)
    else $error("no release");
  wake_hold_a: assert property (wakeup_irq |-> scl_oe && !scl_out)
    else $error("hold lost");
  clr_rel_a: assert property (addr_match_flag && addr_flag_clear |-> ##[1:4] !scl_oe)
    else $error("stuck stretch");
  flag_irq_a: assert property ($rose(addr_match_flag) && stop_mode |-> ##1 wakeup_irq)
    else $error("no irq");
  wake_osc_a: assert property (wakeup_irq |-> osc_request && stop_mode)
    else $error("irq no osc");
  idle_oe_a: assert property (!osc_request |-> !scl_oe)
    else $error("idle stretch");
endmodule // i2cw_stop_wake_monitor
bind i2cw_stop_wake i2cw_stop_wake_monitor u_mon (
  .core_clk           (core_clk),
  .sys_rst            (sys_rst),
  .scl_out            (scl_out),
  .scl_oe             (scl_oe),
  .stop_mode          (stop_mode),
  .kernel_is_fast_osc (kernel_is_fast_osc),
  .osc_ready          (osc_ready),
  .addr_flag_clear    (addr_flag_clear),
  .osc_request        (osc_request),
  .addr_match_flag    (addr_match_flag),
  .wakeup_irq         (wakeup_irq)
);
`default_nettype wire

/* sim/tb_i2cw_stop_wake.sv */
`timescale 1ns/1ps
`default_nettype none
`include "i2cw_defs.svh"
module tb_i2cw_stop_wake;
  logic core_clk = 1'b0, sys_rst = 1'b1, stop_mode, kernel_is_fast_osc, addr_10bit;
  logic osc_ready = 1'b0, addr_flag_clear = 1'b0, hit, req_d, flag_d, scl_m, sda_m;
  logic scl_out, scl_oe, sda_out, sda_oe, osc_request, addr_match_flag, wakeup_irq;
  logic [9:0] own_addr = 10'h000;
  logic [7:0] osc_sr = 8'h00;
  logic q[$];
  int err_count = 0, samples_checked = 0;
  wire scl_in = scl_m & ~(scl_oe & ~scl_out);
  wire sda_in = sda_m & ~(sda_oe & ~sda_out);
  always #2.5 core_clk = ~core_clk;
  i2cw_master m (.scl(scl_in), .sda(sda_in), .scl_m(scl_m), .sda_m(sda_m));
  i2cw_stop_wake dut (
    .core_clk           (core_clk),
    .sys_rst            (sys_rst),
    .scl_in             (scl_in),
    .scl_out            (scl_out),
    .scl_oe             (scl_oe),
    .sda_in             (sda_in),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .stop_mode          (stop_mode),
    .kernel_is_fast_osc (kernel_is_fast_osc),
    .addr_10bit         (addr_10bit),
    .own_addr           (own_addr),
    .osc_ready          (osc_ready),
    .addr_flag_clear    (addr_flag_clear),
    .osc_request        (osc_request),
    .addr_match_flag    (addr_match_flag),
    .wakeup_irq         (wakeup_irq)
  );
  // Oscillator: stable 9 cycles after request, off once dropped
  always @(negedge core_clk) begin
    osc_sr <= {osc_sr[6:0], osc_request};
    osc_ready <= osc_sr[7] & osc_request;
  end
  // Software clears the flag well after wakeup
  always begin
    @(posedge addr_match_flag);
    repeat (20) @(negedge core_clk);
    addr_flag_clear <= 1'b1;
    @(negedge core_clk) addr_flag_clear <= 1'b0;
  end
  task automatic check(input logic r);
    logic e;
    e = q.size() ? q.pop_front() : 1'bx;
    samples_checked++;
    if (r !== e) begin
      $display("[FAIL] %0t exp %h got %h", $time, e, r);
      err_count++;
    end
  endtask
  // Flag rise or request drop closes an address phase
  always @(negedge core_clk) begin
    if (addr_match_flag === 1'b1 && flag_d === 1'b0) check(1'b1);
    if (osc_request === 1'b0 && req_d === 1'b1 && !hit) check(1'b0);
    hit = (osc_request && req_d) ? (hit | addr_match_flag) : 1'b0;
    flag_d = addr_match_flag;
    req_d = osc_request;
  end
  initial begin
    logic [9:0] a;
    logic [7:0] b0;
    int         ack_exp = 0;
    void'($urandom(63));
    repeat (10) @(negedge core_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      a = 10'($urandom);
      own_addr <= a;
      addr_10bit <= (k == 3 || k == 4);
      kernel_is_fast_osc <= (k != 5);
      stop_mode <= (k != 6);
      b0 = (k == 3 || k == 4) ? {`I2CW_HDR10, a[9:8], 1'b0} : {a[6:0], k == 2};
      if (k < 5) q.push_back(k == 0 || k == 3);
      repeat (5) @(negedge core_clk);
      m.xfer({b0 ^ {6'h00, k == 1, 1'b0}, a[7:0] ^ {7'h00, k == 4}}, k == 3 || k == 4);
      repeat (30) @(negedge core_clk);
      // Each matched byte is acknowledged, a refused one is not
      ack_exp += (k == 0 || k == 4) + 2 * (k == 3);
      samples_checked++;
      if (m.acks != ack_exp) begin
        $display("[FAIL] %0t ack exp %h got %h", $time, ack_exp, m.acks);
        err_count++;
      end
      $display("test %0d done", k);
    end
    err_count += (q.size() != 0 || m.tmo != 0);
    report_and_stop();
  end
  initial begin
    #150000;
    err_count++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
endmodule // tb_i2cw_stop_wake
`default_nettype wire
